//--- hw/pcs_consts.svh
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_OFF_CTRL 8'h00
`define PCS_OFF_TOTAL 8'h04
`define PCS_OFF_THR 8'h08
`define PCS_OFF_ACTIVE 8'h0c
`define PCS_OFF_CMD 8'h10
`define PCS_OFF_PSEL 8'h14
`define PCS_OFF_PTHR 8'h18
`define PCS_OFF_MASK 8'h1c
`define PCS_OFF_COUNT 8'h20
`define PCS_CTRL_MODE 0
`define PCS_CTRL_ADV_LSB 1
`define PCS_CTRL_RS_LSB 4
`define PCS_CTRL_EDGE_LSB 8
`define PCS_CTRL_INV 10
`define PCS_CTRL_WIN 12
`define PCS_CMD_RESTART 0
`define PCS_FEAT_ROI 2
`define PCS_RST_IDX 8'h01
`define PCS_RST_TOTAL 8'h01
`define PCS_RST_THR 16'h0001
`endif

//--- hw/pcs_pkg.sv
package pcs_pkg;
	typedef enum logic [2:0] {
		PCS_ADV_NONE,
		PCS_ADV_FRAME_TRIG,
		PCS_ADV_COUNTER,
		PCS_ADV_FRAME_BEGIN,
		PCS_ADV_LINE
	} pcs_adv_t;
	typedef enum logic [2:0] {
		PCS_RS_FRAME_TRIG,
		PCS_RS_COUNTER,
		PCS_RS_TIMER,
		PCS_RS_ACQ_STOP,
		PCS_RS_SOFTWARE
	} pcs_rs_t;
	typedef enum logic [1:0] {
		PCS_EDGE_RISE,
		PCS_EDGE_FALL,
		PCS_EDGE_ANY
	} pcs_edge_t;
	typedef struct packed {
		logic win_sensor;
		logic line_invert;
		pcs_edge_t edge_sel;
		pcs_rs_t rst_src;
		pcs_adv_t adv_src;
		logic mode;
	} pcs_ctrl_t;
	typedef struct packed {
		logic line;
		logic acquisition_stop_event;
		logic timer_one_done;
		logic frame_begin_event;
		logic counter_one_done;
		logic accepted_frame_trigger;
	} pcs_events_t;
endpackage : pcs_pkg

//--- hw/pcs_seq.sv
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "pcs_consts.svh"
module pcs_seq #(
	parameter int MAX_PRESETS = 16,
	parameter int FEAT_W = 7,
	parameter bit SENSOR_ROI_CAPABLE = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic ack_o,
	output logic [31:0] dat_o,
	input wire pcs_pkg::pcs_events_t ev_i,
	output logic [7:0] active_preset_index_o,
	output logic sequencer_enabled_o,
	output logic preset_switch_o,
	output logic [FEAT_W-1:0] feature_update_o,
	output logic sensor_roi_cycle_o
);
	typedef struct packed {
		pcs_pkg::pcs_ctrl_t ctrl;
		logic [7:0] total;
		logic [15:0] thr;
		logic [7:0] psel;
		logic [FEAT_W-1:0] mask;
		logic [MAX_PRESETS-1:0][15:0] pthr;
		logic [7:0] idx;
		logic [15:0] cnt;
		logic line_prev;
		logic en_prev;
		logic ack;
		logic [31:0] rdat;
		logic sw;
		logic [FEAT_W-1:0] upd;
	} pcs_state_t;

	pcs_state_t s_ff;
	pcs_state_t nxt_s;
	logic req;
	logic [31:0] w;
	logic [31:0] r;
	logic line_now;
	logic edge_ok;
	logic ev_sel;
	logic rs_sel;
	logic cmd_wr;
	logic idx_wr;
	logic rst_hit;
	logic [7:0] pidx;
	logic [15:0] thr_eff;
	logic [16:0] cnt_inc;
	logic [FEAT_W-1:0] roi_excl;

	function automatic logic [31:0] pcs_merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++)
		begin
			m[i*8 +: 8] = sel[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
		return m;
	endfunction : pcs_merge

	function automatic logic [7:0] pcs_clamp(input logic [7:0] v,
		input logic [7:0] hi);
		if (v == 8'h00)
			return 8'h01;
		else if (v > hi)
			return hi;
		return v;
	endfunction : pcs_clamp

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.sw = 1'b0;
		nxt_s.upd = '0;
		r = '0;
		w = '0;
		req = cyc_i & stb_i & ~s_ff.ack;
		nxt_s.ack = req;
		cmd_wr = 1'b0;
		idx_wr = 1'b0;
		roi_excl = '0;
		pidx = s_ff.idx - 8'h01;
		thr_eff = s_ff.thr;
		cnt_inc = {1'b0, s_ff.cnt} + 17'h00001;
		line_now = ev_i.line ^ s_ff.ctrl.line_invert;
		nxt_s.line_prev = line_now;
		unique case (s_ff.ctrl.edge_sel)
			pcs_pkg::PCS_EDGE_RISE: edge_ok = line_now & ~s_ff.line_prev;
			pcs_pkg::PCS_EDGE_FALL: edge_ok = ~line_now & s_ff.line_prev;
			default: edge_ok = line_now ^ s_ff.line_prev;
		endcase
		unique case (s_ff.ctrl.adv_src)
			pcs_pkg::PCS_ADV_FRAME_TRIG: ev_sel = ev_i.accepted_frame_trigger;
			pcs_pkg::PCS_ADV_COUNTER: ev_sel = ev_i.counter_one_done;
			pcs_pkg::PCS_ADV_FRAME_BEGIN: ev_sel = ev_i.frame_begin_event;
			pcs_pkg::PCS_ADV_LINE: ev_sel = edge_ok;
			default: ev_sel = 1'b0;
		endcase
		unique case (s_ff.ctrl.rst_src)
			pcs_pkg::PCS_RS_FRAME_TRIG: rs_sel = ev_i.accepted_frame_trigger;
			pcs_pkg::PCS_RS_COUNTER: rs_sel = ev_i.counter_one_done;
			pcs_pkg::PCS_RS_TIMER: rs_sel = ev_i.timer_one_done;
			pcs_pkg::PCS_RS_ACQ_STOP: rs_sel = ev_i.acquisition_stop_event;
			default: rs_sel = 1'b0;
		endcase
		// Register reads
		r[`PCS_CTRL_MODE] = s_ff.ctrl.mode;
		r[`PCS_CTRL_ADV_LSB +: 3] = s_ff.ctrl.adv_src;
		r[`PCS_CTRL_RS_LSB +: 3] = s_ff.ctrl.rst_src;
		r[`PCS_CTRL_EDGE_LSB +: 2] = s_ff.ctrl.edge_sel;
		r[`PCS_CTRL_INV] = s_ff.ctrl.line_invert;
		r[`PCS_CTRL_WIN] = s_ff.ctrl.win_sensor;
		if (req)
		begin
			unique case (adr_i)
				`PCS_OFF_CTRL: w = r;
				`PCS_OFF_TOTAL: w = {24'h0, s_ff.total};
				`PCS_OFF_THR: w = {16'h0, s_ff.thr};
				`PCS_OFF_ACTIVE: w = {24'h0, s_ff.idx};
				`PCS_OFF_PSEL: w = {24'h0, s_ff.psel};
				`PCS_OFF_PTHR:
					if (s_ff.psel < 8'(MAX_PRESETS))
						w = {16'h0, s_ff.pthr[s_ff.psel]};
				`PCS_OFF_MASK: w = 32'(s_ff.mask);
				`PCS_OFF_COUNT: w = {16'h0, s_ff.cnt};
				default: w = '0;
			endcase
			if (!we_i)
				nxt_s.rdat = w;
			w = pcs_merge(w, dat_i, sel_i);
		end
		// Register writes
		if (req && we_i)
		begin
			unique case (adr_i)
				`PCS_OFF_CTRL:
				begin
					nxt_s.ctrl.mode = w[`PCS_CTRL_MODE];
					nxt_s.ctrl.adv_src = pcs_pkg::pcs_adv_t'(
						w[`PCS_CTRL_ADV_LSB +: 3]);
					nxt_s.ctrl.rst_src = pcs_pkg::pcs_rs_t'(
						w[`PCS_CTRL_RS_LSB +: 3]);
					nxt_s.ctrl.edge_sel = pcs_pkg::pcs_edge_t'(
						w[`PCS_CTRL_EDGE_LSB +: 2]);
					nxt_s.ctrl.line_invert = w[`PCS_CTRL_INV];
					nxt_s.ctrl.win_sensor = w[`PCS_CTRL_WIN] &
						SENSOR_ROI_CAPABLE;
				end
				`PCS_OFF_TOTAL: nxt_s.total = pcs_clamp(w[7:0],
					8'(MAX_PRESETS));
				`PCS_OFF_THR: nxt_s.thr = w[15:0];
				`PCS_OFF_ACTIVE: idx_wr = 1'b1;
				`PCS_OFF_CMD: cmd_wr = w[`PCS_CMD_RESTART];
				`PCS_OFF_PSEL: nxt_s.psel = w[7:0];
				`PCS_OFF_PTHR:
					if (s_ff.psel < 8'(MAX_PRESETS))
						nxt_s.pthr[s_ff.psel] = w[15:0];
				`PCS_OFF_MASK: nxt_s.mask = w[FEAT_W-1:0];
				default: ;
			endcase
		end
		// Threshold of the preset in use
		if (pidx < 8'(MAX_PRESETS) && s_ff.pthr[pidx] != 16'h0000)
			thr_eff = s_ff.pthr[pidx];
		if (thr_eff == 16'h0000)
			thr_eff = 16'h0001;
		rst_hit = rs_sel | cmd_wr;
		// Sequencing
		if (s_ff.ctrl.mode)
		begin
			if (rst_hit)
			begin
				nxt_s.idx = 8'h01;
				nxt_s.cnt = 16'h0000;
			end
			else if (s_ff.ctrl.adv_src == pcs_pkg::PCS_ADV_NONE)
			begin
				if (idx_wr)
					nxt_s.idx = pcs_clamp(w[7:0], s_ff.total);
			end
			else if (ev_sel)
			begin
				if (cnt_inc >= {1'b0, thr_eff})
				begin
					nxt_s.cnt = 16'h0000;
					if (s_ff.idx >= s_ff.total)
						nxt_s.idx = 8'h01;
					else
						nxt_s.idx = s_ff.idx + 8'h01;
				end
				else
					nxt_s.cnt = cnt_inc[15:0];
			end
		end
		// Preset application
		nxt_s.en_prev = s_ff.ctrl.mode;
		nxt_s.sw = s_ff.ctrl.mode &
			((nxt_s.idx != s_ff.idx) | ~s_ff.en_prev);
		roi_excl[`PCS_FEAT_ROI] = s_ff.ctrl.win_sensor;
		if (nxt_s.sw)
			nxt_s.upd = s_ff.mask & ~roi_excl;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_ff <= '0;
			s_ff.idx <= `PCS_RST_IDX;
			s_ff.total <= `PCS_RST_TOTAL;
			s_ff.thr <= `PCS_RST_THR;
		end
		else if (ce_i)
			s_ff <= nxt_s;
	end

	assign ack_o = s_ff.ack;
	assign dat_o = s_ff.rdat;
	assign active_preset_index_o = s_ff.idx;
	assign sequencer_enabled_o = s_ff.ctrl.mode;
	assign preset_switch_o = s_ff.sw;
	assign feature_update_o = s_ff.upd;
	assign sensor_roi_cycle_o = s_ff.ctrl.win_sensor;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_mode_off_hold: assert property (
		ce_i && !s_ff.ctrl.mode |=> $stable(s_ff.idx) && !s_ff.sw)
		else $error("index moved while sequencer off");
	a_none_no_step: assert property (
		ce_i && s_ff.ctrl.adv_src == pcs_pkg::PCS_ADV_NONE && !rst_hit
		&& !idx_wr |=> $stable(s_ff.idx))
		else $error("index stepped with no advance source");
	a_adv_counts: assert property (
		ce_i && s_ff.ctrl.mode && ev_sel && !rst_hit |=>
		s_ff.cnt == 16'h0000 || s_ff.cnt == $past(s_ff.cnt) + 16'h0001)
		else $error("advance event not counted");
	a_line_fall: assert property (
		s_ff.ctrl.adv_src == pcs_pkg::PCS_ADV_LINE &&
		s_ff.ctrl.edge_sel == pcs_pkg::PCS_EDGE_FALL |->
		ev_sel == (s_ff.line_prev && !(ev_i.line ^ s_ff.ctrl.line_invert)))
		else $error("falling edge not qualified");
	a_repeat_hold: assert property (
		ce_i && s_ff.ctrl.mode && ev_sel && !rst_hit &&
		cnt_inc < {1'b0, thr_eff} |=> $stable(s_ff.idx))
		else $error("index stepped before repeat count");
	a_restart_one: assert property (
		ce_i && s_ff.ctrl.mode && rs_sel |=>
		s_ff.idx == 8'h01 && s_ff.cnt == 16'h0000)
		else $error("restart source did not restart");
	a_cmd_restart: assert property (
		ce_i && s_ff.ctrl.mode && cmd_wr |=>
		s_ff.idx == 8'h01 && s_ff.cnt == 16'h0000)
		else $error("restart command did not restart");
	a_read_index: assert property (
		ce_i && req && !we_i && adr_i == `PCS_OFF_ACTIVE |=>
		ack_o && dat_o == {24'h0, $past(s_ff.idx)})
		else $error("active index read wrong");
	a_wrap_one: assert property (
		ce_i && s_ff.ctrl.mode && ev_sel && !rst_hit &&
		s_ff.ctrl.adv_src != pcs_pkg::PCS_ADV_NONE &&
		cnt_inc >= {1'b0, thr_eff} && s_ff.idx >= s_ff.total |=>
		s_ff.idx == 8'h01)
		else $error("index did not wrap to one");
	a_sensor_roi: assert property (
		ce_i && s_ff.ctrl.win_sensor |=> !s_ff.upd[`PCS_FEAT_ROI])
		else $error("ROI update while sensor cycles ROI");
	a_update_mask: assert property (
		ce_i |=> (s_ff.upd & ~$past(s_ff.mask)) == '0 &&
		(s_ff.upd == '0 || s_ff.sw))
		else $error("unmasked feature updated");

	c_wrap: cover property (s_ff.idx == s_ff.total ##1 s_ff.idx == 8'h01);
	c_restart: cover property (s_ff.ctrl.mode && cmd_wr);
	c_repeat: cover property (ev_sel && cnt_inc < {1'b0, thr_eff}
		##[1:20] s_ff.sw);
	c_read: cover property (req && !we_i && adr_i == `PCS_OFF_ACTIVE);
endmodule : pcs_seq

//--- test/pcs_seq_bench.sv
`timescale 1ns/1ps
`include "pcs_consts.svh"
module pcs_seq_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [5:0] ev_r = 6'h00;
	logic ack;
	logic [31:0] dat;
	logic [7:0] idx;
	logic en;
	logic sw;
	logic [6:0] fu;
	logic roi;
	logic [31:0] rd;
	logic esw = 1'b0;
	int fail_count = 0;
	int checks_done = 0;
	int mi = 1, mc = 0, tot = 1, thr = 1, mask = 0, pl = 0, ctl = 0;
	int mode = 0, adv = 0, rs = 0, edg = 0, inv = 0, win = 0;
	int pthr[16];
	logic [7:0] ra[5] = '{`PCS_OFF_TOTAL, `PCS_OFF_THR, `PCS_OFF_ACTIVE,
		`PCS_OFF_COUNT, 8'h3c};
	int rv[5] = '{1, 1, 1, 0, 0};
	always #10 clk_i = ~clk_i;
	pcs_seq i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wd),
		.ack_o(ack), .dat_o(dat), .ev_i(pcs_pkg::pcs_events_t'(ev_r)),
		.active_preset_index_o(idx), .sequencer_enabled_o(en),
		.preset_switch_o(sw), .feature_update_o(fu),
		.sensor_roi_cycle_o(roi));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			fail_count++;
			$display("ERROR t=%0t got %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	// Drive one cycle of events, compare the previous cycle's result
	task automatic step(input logic [5:0] e);
		int lv, hit, rh, t, old;
		@(posedge clk_i);
		ev_r <= e;
		#1;
		chk(idx, mi);
		chk(sw, esw);
		chk(fu, esw ? mask & (win ? 'h7b : 'h7f) : 0);
		chk(en, mode);
		chk(roi, win);
		lv = e[5] ^ inv;
		case (adv)
			1: hit = e[0];
			2: hit = e[1];
			3: hit = e[2];
			4: hit = edg == 0 ? (lv && !pl) : edg == 1 ? (!lv && pl) : lv != pl;
			default: hit = 0;
		endcase
		rh = rs == 0 ? e[0] : rs == 1 ? e[1] : rs == 2 ? e[3] : rs == 3 ? e[4] : 0;
		pl = lv;
		old = mi;
		if (mode && rh)
		begin
			mi = 1;
			mc = 0;
		end
		else if (mode && hit)
		begin
			mc++;
			t = pthr[mi-1] != 0 ? pthr[mi-1] : (thr == 0 ? 1 : thr);
			if (mc >= t)
			begin
				mc = 0;
				mi = mi >= tot ? 1 : mi + 1;
			end
		end
		esw = mode && mi != old;
	endtask : step
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		step({ev_r[5], 5'h00});
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		rd = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
		@(posedge clk_i);
	endtask : wb
	initial
	begin
		void'($urandom(25910));
		foreach (pthr[k])
			pthr[k] = 0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ra[k])
		begin
			wb(1'b0, ra[k], 32'h0);
			chk(rd, rv[k]);
		end
		$display("test reset done");
		for (int i = 0; i < 15; i++)
		begin
			adv = i % 5;
			edg = i / 5;
			rs = (i * 3 + i / 5) % 5;
			tot = $urandom_range(1, 5);
			thr = $urandom_range(0, 3);
			mask = $urandom_range(0, 127);
			ctl = adv << 1 | rs << 4 | edg << 8 | ($urandom & 'h1400);
			wb(1'b1, `PCS_OFF_CTRL, ctl);
			mode = 0;
			inv = ctl >> 10 & 1;
			win = ctl >> 12 & 1;
			wb(1'b1, `PCS_OFF_TOTAL, tot);
			wb(1'b1, `PCS_OFF_THR, thr);
			wb(1'b1, `PCS_OFF_MASK, mask);
			for (int p = 0; p < 5; p++)
			begin
				pthr[p] = $urandom_range(0, 2);
				wb(1'b1, `PCS_OFF_PSEL, p);
				wb(1'b1, `PCS_OFF_PTHR, pthr[p]);
			end
			wb(1'b1, `PCS_OFF_CTRL, ctl | (i != 1));
			mode = i != 1;
			pl = ev_r[5] ^ inv;
			wb(1'b1, `PCS_OFF_CMD, 32'h1);
			if (mode)
			begin
				mi = 1;
				mc = 0;
			end
			wb(1'b0, `PCS_OFF_COUNT, 32'h0);
			chk(rd, mc);
			repeat (40) step(6'($urandom & $urandom));
			wb(1'b0, `PCS_OFF_COUNT, 32'h0);
			chk(rd, mc);
			ctl = $urandom_range(1, 6);
			wb(1'b1, `PCS_OFF_ACTIVE, ctl);
			if (mode && adv == 0)
				mi = ctl > tot ? tot : ctl;
			wb(1'b0, `PCS_OFF_ACTIVE, 32'h0);
			chk(rd, mi);
			$display("test %0d done", i);
		end
		wrap_up();
	end
	initial
	begin
		repeat (30000) @(posedge clk_i);
		fail_count++;
		$display("ERROR t=%0t watchdog expired", $time);
		wrap_up();
	end
endmodule : pcs_seq_bench
